// ==== acs_device.sv ====
/*
 * Converter end of the link: internally timed successive approximation,
 * conversion select handling and serial readout of the result.
 * Assumes clk_i at 200 MHz, sample_i synchronous to clk_i, and a host that
 * keeps the shift clock still while a conversion runs.
 */
// What this block and its host do
// [R01] Select falling edge: hold sample, convert, drive low.
// [R02] Host keeps shift clock idle during conversion.
// [R03] Data output rises to mark conversion done.
// [R04] Result held internally, readable any time after.
// [R05] Output changes on shift falls, MSB first.
// [R06] Frame is leading one plus twelve bits.
// [R07] Extra shift pulses give zeros, no side effect.
// [R08] Host raises select after LSB, waits acquisition.
// [R09] Result is unsigned binary, step is reference/4096.
// [R10] Host is clock master, at most 2.5MHz.
// [R11] Host keeps shift clock low when selecting.
// [R12] Host waits conversion time or data rise.
// [R13] Host samples data on shift clock rise.
// [R14] Host raises select at or after 13th fall.
// [R15] Host keeps select high for minimum time.
// [R16] Select rising mid-conversion aborts the conversion.
// [R17] Conversion finishes within 8.5us, own timing.
// [R18] Host allows at least 1.5us acquisition.
// [R19] Shift clock phases each at least 100ns.
// [R20] Select high: output released, shift clock ignored.
`timescale 1ns/100ps

module acs_device #(
   parameter int CONV_CYC = acs_pkg::CONV_CYC,
   parameter int STEP_CYC = acs_pkg::STEP_CYC
) (
   // System clock and reset.
   input  wire logic                      clk_i,
   input  wire logic                      rstn_i,
   // Link to the host.
   acs_link_if.dev                        lnk,
   // Analog stand-in: the input as a code.
   input  wire logic [acs_pkg::RES_W-1:0] sample_i,
   // Status towards the user side.
   output logic                           busy_o,
   output logic                           done_o,
   output logic [acs_pkg::RES_W-1:0]      result_o
);

   typedef enum logic [2:0] {
      ACS_IDLE  = 3'b001,
      ACS_CONV  = 3'b010,
      ACS_READY = 3'b100
   } acs_dev_state_t;

   // Shift clock domain: count of falling edges in the current frame.
   // The count is cleared while select is high, so the frame's own signal
   // ends it and no shift clock edge is needed after the last bit.
   logic                      frame_clr;
   logic [acs_pkg::CNT_W-1:0] edge_gray;
   logic [acs_pkg::CNT_W-1:0] next_edge_gray;
   logic [acs_pkg::CNT_W-1:0] edge_bin;

   assign frame_clr = lnk.cs_n | ~rstn_i;

   always_comb begin
      edge_bin       = acs_pkg::gray2bin(edge_gray);
      next_edge_gray = edge_gray;
      // Saturate after the last bit so extra pulses only hold zeros.
      if (edge_bin != acs_pkg::CNT_W'(acs_pkg::FRAME_BITS)) begin // [R07]
         next_edge_gray = acs_pkg::bin2gray(edge_bin + 4'h1);
      end
   end

   always_ff @(negedge lnk.sclk or posedge frame_clr) begin // [R05] [R20]
      if (frame_clr) begin
         edge_gray <= 4'h0;
      end else begin
         edge_gray <= next_edge_gray;
      end
   end

   // System clock domain: synchronisers for select and the gray count.
   logic                      cs_meta;
   logic                      cs_sync;
   logic [acs_pkg::CNT_W-1:0] gray_meta;
   logic [acs_pkg::CNT_W-1:0] gray_sync;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cs_meta   <= 1'b1;
         cs_sync   <= 1'b1;
         gray_meta <= 4'h0;
         gray_sync <= 4'h0;
      end else begin
         cs_meta   <= lnk.cs_n;
         cs_sync   <= cs_meta;
         gray_meta <= edge_gray;
         gray_sync <= gray_meta;
      end
   end

   // Conversion control and output pin.
   acs_dev_state_t               state;
   acs_dev_state_t               next_state;
   logic [acs_pkg::TMR_W-1:0]    timer;
   logic [acs_pkg::TMR_W-1:0]    next_timer;
   logic [acs_pkg::TMR_W-1:0]    step_tmr;
   logic [acs_pkg::TMR_W-1:0]    next_step_tmr;
   logic [acs_pkg::CNT_W-1:0]    steps_left;
   logic [acs_pkg::CNT_W-1:0]    next_steps_left;
   logic [acs_pkg::RES_W-1:0]    held;
   logic [acs_pkg::RES_W-1:0]    next_held;
   logic [acs_pkg::RES_W-1:0]    sar;
   logic [acs_pkg::RES_W-1:0]    next_sar;
   logic [acs_pkg::RES_W-1:0]    next_result;
   logic                         next_busy;
   logic                         next_done;
   logic                         dout;
   logic                         next_dout;
   logic                         dout_oe_n;
   logic                         next_dout_oe_n;

   always_comb begin
      logic [acs_pkg::RES_W-1:0] trial;
      logic [acs_pkg::CNT_W-1:0] edges;
      logic [acs_pkg::CNT_W-1:0] pos;
      trial           = '0;
      edges           = acs_pkg::gray2bin(gray_sync);
      pos             = 4'h0;
      next_state      = state;
      next_timer      = timer;
      next_step_tmr   = step_tmr;
      next_steps_left = steps_left;
      next_held       = held;
      next_sar        = sar;
      next_result     = result_o;
      next_busy       = busy_o;
      next_done       = 1'b0;
      next_dout       = dout;
      next_dout_oe_n  = dout_oe_n;
      case (state)
         ACS_IDLE: begin
            next_dout_oe_n = 1'b1; // [R20]
            next_dout      = 1'b0;
            if (!cs_sync) begin
               // Freeze the input and start converting with the pin low.
               next_held       = sample_i; // [R01]
               next_sar        = '0;
               next_timer      = '0;
               next_step_tmr   = '0;
               next_steps_left = acs_pkg::CNT_W'(acs_pkg::RES_W);
               next_busy       = 1'b1;
               next_dout       = 1'b0; // [R01]
               next_dout_oe_n  = 1'b0; // [R01]
               next_state      = ACS_CONV;
            end
         end
         ACS_CONV: begin
            if (cs_sync) begin
               // Early select rise throws the conversion away.
               next_busy      = 1'b0; // [R16]
               next_dout_oe_n = 1'b1; // [R16]
               next_dout      = 1'b0;
               next_state     = ACS_IDLE;
            end else begin
               next_timer = timer + 11'h001;
               if (steps_left != 4'h0) begin
                  if (step_tmr == acs_pkg::TMR_W'(STEP_CYC - 1)) begin
                     // One binary-weighted trial per step, plain unsigned code.
                     pos             = steps_left - 4'h1;
                     trial           = sar | (acs_pkg::RES_W'(1) << pos); // [R09]
                     next_sar        = (held >= trial) ? trial : sar; // [R09]
                     next_steps_left = steps_left - 4'h1;
                     next_step_tmr   = '0;
                  end else begin
                     next_step_tmr = step_tmr + 11'h001;
                  end
               end
               if (timer == acs_pkg::TMR_W'(CONV_CYC - 1)) begin // [R17]
                  next_result = sar; // [R04]
                  next_busy   = 1'b0;
                  next_done   = 1'b1;
                  next_dout   = 1'b1; // [R03]
                  next_state  = ACS_READY;
               end
            end
         end
         ACS_READY: begin
            if (cs_sync) begin
               next_dout_oe_n = 1'b1; // [R20]
               next_dout      = 1'b0;
               next_state     = ACS_IDLE;
            end else if (edges == 4'h0) begin
               next_dout = 1'b1; // [R06]
            end else if (edges < acs_pkg::CNT_W'(acs_pkg::FRAME_BITS)) begin
               // Edge n presents bit RES_W-n, so the MSB comes first.
               pos       = acs_pkg::CNT_W'(acs_pkg::RES_W) - edges;
               next_dout = result_o[pos]; // [R05] [R06]
            end else begin
               next_dout = 1'b0; // [R07]
            end
         end
         default: begin
            next_busy      = 1'b0;
            next_dout      = 1'b0;
            next_dout_oe_n = 1'b1;
            next_state     = ACS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state      <= ACS_IDLE;
         timer      <= '0;
         step_tmr   <= '0;
         steps_left <= 4'h0;
         held       <= '0;
         sar        <= '0;
         result_o   <= '0;
         busy_o     <= 1'b0;
         done_o     <= 1'b0;
         dout       <= 1'b0;
         dout_oe_n  <= 1'b1;
      end else begin
         state      <= next_state;
         timer      <= next_timer;
         step_tmr   <= next_step_tmr;
         steps_left <= next_steps_left;
         held       <= next_held;
         sar        <= next_sar;
         result_o   <= next_result;
         busy_o     <= next_busy;
         done_o     <= next_done;
         dout       <= next_dout;
         dout_oe_n  <= next_dout_oe_n;
      end
   end

   assign lnk.dout      = dout;
   assign lnk.dout_oe_n = dout_oe_n;

endmodule

// ==== acs_host.sv ====
/*
 * Host end of the link: starts a conversion, waits for the end marker or
 * the conversion time, clocks in the thirteen-bit frame and returns the
 * twelve-bit result. Assumes clk_i at 200 MHz; the shift clock is made
 * here by dividing clk_i.
 */
`timescale 1ns/100ps

module acs_host #(
   parameter int GAP_CYC  = acs_pkg::ACQ_CYC,
   parameter int HALF_CYC = acs_pkg::SCLK_HALF_CYC,
   parameter int WAIT_CYC = acs_pkg::CONV_CYC + acs_pkg::EOC_MARGIN_CYC
) (
   // System clock and reset.
   input  wire logic                      clk_i,
   input  wire logic                      rstn_i,
   // Link to the converter.
   acs_link_if.host                       lnk,
   // User request and answer.
   input  wire logic                      start_i,
   output logic                           busy_o,
   output logic                           valid_o,
   output logic                           frame_err_o,
   output logic [acs_pkg::RES_W-1:0]      data_o
);

   typedef enum logic [5:0] {
      ACS_H_GAP  = 6'b000001,
      ACS_H_IDLE = 6'b000010,
      ACS_H_EOC  = 6'b000100,
      ACS_H_LOW  = 6'b001000,
      ACS_H_HIGH = 6'b010000,
      ACS_H_END  = 6'b100000
   } acs_host_state_t;

   logic dout_meta;
   logic dout_sync;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         dout_meta <= 1'b0;
         dout_sync <= 1'b0;
      end else begin
         dout_meta <= lnk.dout_line;
         dout_sync <= dout_meta;
      end
   end

   acs_host_state_t                   state;
   acs_host_state_t                   next_state;
   logic [acs_pkg::TMR_W-1:0]         timer;
   logic [acs_pkg::TMR_W-1:0]         next_timer;
   logic [acs_pkg::CNT_W-1:0]         bits;
   logic [acs_pkg::CNT_W-1:0]         next_bits;
   logic [acs_pkg::FRAME_BITS-1:0]    shreg;
   logic [acs_pkg::FRAME_BITS-1:0]    next_shreg;
   logic                              cs_n;
   logic                              next_cs_n;
   logic                              sclk;
   logic                              next_sclk;
   logic                              next_busy;
   logic                              next_valid;
   logic                              next_err;
   logic [acs_pkg::RES_W-1:0]         next_data;

   always_comb begin
      next_state = state;
      next_timer = timer;
      next_bits  = bits;
      next_shreg = shreg;
      next_cs_n  = cs_n;
      next_sclk  = sclk;
      next_busy  = busy_o;
      next_valid = 1'b0;
      next_err   = frame_err_o;
      next_data  = data_o;
      case (state)
         ACS_H_GAP: begin
            // Select stays high long enough to reacquire the input.
            next_timer = timer + 11'h001;
            if (timer >= acs_pkg::TMR_W'(GAP_CYC - 1)) begin // [R08] [R15] [R18]
               next_busy  = 1'b0;
               next_state = ACS_H_IDLE;
            end
         end
         ACS_H_IDLE: begin
            if (start_i) begin
               next_cs_n  = 1'b0; // [R11]
               next_sclk  = 1'b0; // [R11]
               next_timer = '0;
               next_bits  = 4'h0;
               next_busy  = 1'b1;
               next_state = ACS_H_EOC;
            end
         end
         ACS_H_EOC: begin
            // Shift clock stays low until the end marker or the timeout.
            next_timer = timer + 11'h001;
            // A released line reads high, so the marker only counts once the
            // converter has had time to pull the line low.
            if ((dout_sync && timer >= acs_pkg::TMR_W'(acs_pkg::EOC_MARGIN_CYC))
                || timer >= acs_pkg::TMR_W'(WAIT_CYC - 1)) begin // [R02] [R12]
               next_timer = '0;
               next_state = ACS_H_LOW;
            end
         end
         ACS_H_LOW: begin
            next_timer = timer + 11'h001;
            if (timer >= acs_pkg::TMR_W'(HALF_CYC - 1)) begin // [R10] [R19]
               next_sclk  = 1'b1;
               next_shreg = {shreg[acs_pkg::FRAME_BITS-2:0], dout_sync}; // [R13]
               next_bits  = bits + 4'h1;
               next_timer = '0;
               next_state = ACS_H_HIGH;
            end
         end
         ACS_H_HIGH: begin
            next_timer = timer + 11'h001;
            if (timer >= acs_pkg::TMR_W'(HALF_CYC - 1)) begin // [R19]
               next_sclk  = 1'b0;
               next_timer = '0;
               if (bits == acs_pkg::CNT_W'(acs_pkg::FRAME_BITS)) begin // [R06]
                  next_state = ACS_H_END;
               end else begin
                  next_state = ACS_H_LOW;
               end
            end
         end
         ACS_H_END: begin
            // Select rises only after the thirteenth falling edge.
            next_timer = timer + 11'h001;
            if (timer >= acs_pkg::TMR_W'(HALF_CYC - 1)) begin
               next_cs_n  = 1'b1; // [R14]
               next_data  = shreg[acs_pkg::RES_W-1:0];
               next_err   = ~shreg[acs_pkg::FRAME_BITS-1];
               next_valid = shreg[acs_pkg::FRAME_BITS-1];
               next_timer = '0;
               next_state = ACS_H_GAP;
            end
         end
         default: begin
            next_cs_n  = 1'b1;
            next_sclk  = 1'b0;
            next_timer = '0;
            next_state = ACS_H_GAP;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state       <= ACS_H_GAP;
         timer       <= '0;
         bits        <= 4'h0;
         shreg       <= '0;
         cs_n        <= 1'b1;
         sclk        <= 1'b0;
         busy_o      <= 1'b1;
         valid_o     <= 1'b0;
         frame_err_o <= 1'b0;
         data_o      <= '0;
      end else begin
         state       <= next_state;
         timer       <= next_timer;
         bits        <= next_bits;
         shreg       <= next_shreg;
         cs_n        <= next_cs_n;
         sclk        <= next_sclk;
         busy_o      <= next_busy;
         valid_o     <= next_valid;
         frame_err_o <= next_err;
         data_o      <= next_data;
      end
   end

   assign lnk.cs_n = cs_n;
   assign lnk.sclk = sclk;

endmodule

// ==== acs_link_chk.sv ====
/* Checker for one converter link: select, shift clock and data timing.
   Assumes the shift clock is made from clk_i, as the host end does. */
`timescale 1ns/100ps
module acs_link_chk #(
   parameter int CONV_CYC = acs_pkg::CONV_CYC,
   parameter int ACQ_CYC  = acs_pkg::ACQ_CYC
) (
   // Clock and reset.
   input  wire logic clk_i,
   input  wire logic rstn_i,
   // Link wires.
   input  wire logic cs_n,
   input  wire logic sclk,
   input  wire logic dout,
   input  wire logic dout_oe_n,
   input  wire logic dout_line
);
   logic        oe_q, sclk_q, fall, conv, rdy, next_conv, next_rdy;
   logic [3:0]  age, nfall, next_age, next_nfall;
   logic [10:0] ccnt, next_ccnt;
   logic [10:0] hi, next_hi;

   // Conversion and frame progress, rebuilt from the wires alone.
   always_comb begin
      fall       = sclk_q & ~sclk;
      next_conv  = ~cs_n & ((oe_q & ~dout_oe_n) | (conv & ~dout_line));
      next_rdy   = ~cs_n & ((conv & dout_line) | rdy);
      next_ccnt  = conv ? ccnt + 11'h001 : 11'h000;
      next_age   = fall ? 4'h0 : (age == 4'hF) ? age : age + 4'h1;
      next_nfall = !rdy ? 4'h0 : (fall && nfall != 4'hF) ? nfall + 4'h1 : nfall;
      next_hi    = !cs_n ? 11'h000 : (hi == 11'h7FF) ? hi : hi + 11'h001;
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         oe_q   <= 1'b1;
         sclk_q <= 1'b0;
         conv   <= 1'b0;
         rdy    <= 1'b0;
         ccnt   <= 11'h000;
         age    <= 4'hF;
         nfall  <= 4'h0;
         hi     <= 11'h000;
      end else begin
         oe_q   <= dout_oe_n;
         sclk_q <= sclk;
         conv   <= next_conv;
         rdy    <= next_rdy;
         ccnt   <= next_ccnt;
         age    <= next_age;
         nfall  <= next_nfall;
         hi     <= next_hi;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   sequence s_low;      ##[2:5] (!dout_oe_n && !dout && !dout_line); endsequence
   sequence s_released; ##[2:5] dout_oe_n;                  endsequence

   property p_start;  $fell(cs_n) |-> s_low; endproperty
   property p_rel;    $rose(cs_n) |-> s_released; endproperty
   property p_idle;   cs_n [*6] |-> dout_oe_n; endproperty
   property p_quiet;  conv |-> !sclk; endproperty
   property p_sel;    $fell(cs_n) |-> !sclk; endproperty
   property p_eoc;    (conv && dout_line) |-> (ccnt + 8 >= CONV_CYC && ccnt <= CONV_CYC + 8);
   endproperty
   property p_limit;  ccnt <= CONV_CYC + 8; endproperty
   property p_shift;  (rdy && !cs_n && $changed(dout_line)) |-> age <= 4'h6; endproperty
   property p_lead;   (rdy && !cs_n && nfall == 4'h0) |-> dout_line; endproperty
   property p_trail;  (rdy && !cs_n && nfall >= 4'hD && age > 4'h6) |-> !dout_line;
   endproperty
   property p_full;   ($rose(cs_n) && rdy) |-> nfall >= 4'hD; endproperty
   property p_acq;    $fell(cs_n) |-> hi + 1 >= ACQ_CYC; endproperty

   a_start: assert property (p_start) else $error("data not driven low after select");
   a_rel:   assert property (p_rel) else $error("data not released after select rise");
   a_idle:  assert property (p_idle) else $error("data driven while deselected");
   a_quiet: assert property (p_quiet) else $error("shift clock high in conversion");
   a_sel:   assert property (p_sel) else $error("shift clock high at select fall");
   a_eoc:   assert property (p_eoc) else $error("end marker at wrong time");
   a_limit: assert property (p_limit) else $error("conversion overran its time");
   a_shift: assert property (p_shift) else $error("data changed away from a fall");
   a_lead:  assert property (p_lead) else $error("leading one missing");
   a_trail: assert property (p_trail) else $error("trailing bit not zero");
   a_full:  assert property (p_full) else $error("select raised before frame end");
   a_acq:   assert property (p_acq) else $error("select high time too short");
endmodule

// ==== acs_link_if.sv ====
/*
 * Three-wire link between the converter and its host: select, shift clock
 * and serial data. The data pin is resolved here from its enable; an
 * undriven data line is pulled high.
 */
`timescale 1ns/100ps

interface acs_link_if;
   logic cs_n;
   logic sclk;
   logic dout;
   logic dout_oe_n;
   logic dout_line;

   assign dout_line = dout_oe_n | dout;

   modport dev (
      input  cs_n,
      input  sclk,
      output dout,
      output dout_oe_n
   );

   modport host (
      output cs_n,
      output sclk,
      input  dout_line
   );
endinterface

// ==== acs_pkg.sv ====
/*
 * Shared constants for the converter link: result width, frame length,
 * conversion and acquisition timing, shift clock half period, and the
 * gray-code helpers used to carry the edge count across clock domains.
 * Assumes both ends run their system clock at 200 MHz.
 */
package acs_pkg;

   // System clock rate and the resulting cycle counts.
   localparam int CLK_MHZ        = 200;
   localparam int CONV_NS        = 8500;
   localparam int CONV_CYC       = (CONV_NS * CLK_MHZ) / 1000;
   localparam int ACQ_NS         = 1500;
   localparam int ACQ_CYC        = (ACQ_NS * CLK_MHZ + 999) / 1000;
   localparam int SCLK_HALF_NS   = 200;
   localparam int SCLK_HALF_CYC  = (SCLK_HALF_NS * CLK_MHZ + 999) / 1000;
   localparam int EOC_MARGIN_CYC = 16;

   // Result and frame layout.
   localparam int RES_W          = 12;
   localparam int FULL_SCALE     = 4096;
   localparam int FRAME_BITS     = 13;
   localparam int STEP_CYC       = CONV_CYC / RES_W;
   localparam int CNT_W          = 4;
   localparam int TMR_W          = 11;

   function automatic logic [CNT_W-1:0] bin2gray(input logic [CNT_W-1:0] b);
      return b ^ (b >> 1);
   endfunction

   function automatic logic [CNT_W-1:0] gray2bin(input logic [CNT_W-1:0] g);
      logic [CNT_W-1:0] b;
      b[CNT_W-1] = g[CNT_W-1];
      for (int i = CNT_W - 2; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction

endpackage

// ==== adc_conversion_serial_readout_tb.sv ====
/* Testbench: host and converter joined by one link, and a second converter
   driven by hand with a 48 ns shift clock. Assumes one 200 MHz system clock. */
`timescale 1ns/100ps
module adc_conversion_serial_readout_tb;
   localparam int CONV = 200;
   localparam int GAP  = 20;
   logic        clk_i    = 1'b0;
   logic        rstn_i   = 1'b0;
   logic        start_i  = 1'b0;
   logic [11:0] sample_a = 12'h000;
   logic [11:0] sample_b = 12'h000;
   logic [11:0] exp_c;
   logic [15:0] lfsr     = 16'h005F;
   logic [12:0] wire_bits;
   logic [15:0] bits_b;
   logic        busy_d, done_d, busy_h, valid_h, ferr_h, busy_b, done_b;
   logic [11:0] res_d, data_h, res_b;
   int          fails = 0, n_tests = 0, n_done_b = 0, n_done_a = 0, k;

   acs_link_if lnk ();
   acs_link_if lnk2 ();

   always #2.5 clk_i = ~clk_i;

   acs_device #(.CONV_CYC(CONV), .STEP_CYC(16)) i_acs_device (.clk_i(clk_i),
      .rstn_i(rstn_i), .lnk(lnk.dev), .sample_i(sample_a), .busy_o(busy_d),
      .done_o(done_d), .result_o(res_d));
   acs_host #(.GAP_CYC(GAP), .HALF_CYC(8), .WAIT_CYC(CONV + 16)) i_acs_host (
      .clk_i(clk_i), .rstn_i(rstn_i), .lnk(lnk.host), .start_i(start_i),
      .busy_o(busy_h), .valid_o(valid_h), .frame_err_o(ferr_h), .data_o(data_h));
   acs_device #(.CONV_CYC(CONV), .STEP_CYC(16)) i_acs_device_b (.clk_i(clk_i),
      .rstn_i(rstn_i), .lnk(lnk2.dev), .sample_i(sample_b), .busy_o(busy_b),
      .done_o(done_b), .result_o(res_b));
   acs_link_chk #(.CONV_CYC(CONV), .ACQ_CYC(GAP)) i_acs_link_chk (.clk_i(clk_i),
      .rstn_i(rstn_i), .cs_n(lnk.cs_n), .sclk(lnk.sclk), .dout(lnk.dout),
      .dout_oe_n(lnk.dout_oe_n), .dout_line(lnk.dout_line));

   // The wire is sampled on rising shift edges, as a host would.
   always @(posedge lnk.sclk) if (!lnk.cs_n) wire_bits <= {wire_bits[11:0], lnk.dout_line};
   always @(posedge clk_i) if (done_b) n_done_b <= n_done_b + 1;
   always @(posedge clk_i) if (done_d) n_done_a <= n_done_a + 1;

   function automatic logic [15:0] lfsr_next(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction

   function automatic logic [12:0] exp_frame(input logic [11:0] code);
      return {1'b1, code};
   endfunction

   task automatic tally_and_finish;
      $display("checks %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   // Bounded wait for host valid, device busy or the second link's end marker.
   task automatic wait_for(input int sel);
      int i;
      for (i = 0; i < 4000; i++) begin
         @(negedge clk_i);
         if ((sel == 0 ? valid_h : sel == 1 ? busy_d : lnk2.dout_line) === 1'b1) break;
      end
      if (i == 4000) begin
         fails++;
         tally_and_finish();
      end
   endtask

   // Hand-made shift pulses; the clock stands still between calls.
   task automatic pulse_b(input int n);
      repeat (n) begin
         #24 lnk2.sclk = 1'b1;
         bits_b = {bits_b[14:0], lnk2.dout_line};
         #24 lnk2.sclk = 1'b0;
      end
      @(negedge clk_i);
   endtask

   initial begin
      lnk2.cs_n = 1'b1;
      lnk2.sclk = 1'b0;
      repeat (10) @(negedge clk_i);
      rstn_i  = 1'b1;
      start_i = 1'b1;
      // Back-to-back conversions; the input moves while each one runs.
      for (k = 0; k < 8; k++) begin
         sample_a = (k == 0) ? 12'h000 : (k == 1) ? 12'hFFF : lfsr[11:0];
         exp_c    = sample_a;
         wait_for(1);
         sample_a = ~exp_c;
         wait_for(0);
         check("host data", exp_c, data_h);
         check("device result", exp_c, res_d);
         check("wire frame", exp_frame(exp_c), wire_bits);
         check("frame flag", 0, ferr_h);
         check("device done", k + 1, n_done_a[15:0]);
         check("device busy", 0, busy_d);
         check("host busy", 1, busy_h);
         lfsr = lfsr_next(lfsr);
      end
      start_i  = 1'b0;
      sample_b = lfsr[11:0];
      // Shift pulses while deselected leave the pin released.
      pulse_b(4);
      check("released pin", 1, lnk2.dout_oe_n);
      check("host idle", 0, busy_h);
      // Select, then abort in mid-conversion.
      lnk2.cs_n = 1'b0;
      repeat (40) @(negedge clk_i);
      check("converting", 3'b001, {lnk2.dout_oe_n, lnk2.dout_line, busy_b});
      lnk2.cs_n = 1'b1;
      repeat (CONV + 20) @(negedge clk_i);
      check("aborted", 2'b01, {busy_b, lnk2.dout_oe_n});
      check("aborted done", 0, n_done_b[15:0]);
      // Full read with three extra pulses.
      lnk2.cs_n = 1'b0;
      // The released line reads high, so let the converter drive it low first.
      repeat (10) @(negedge clk_i);
      check("driven low", 0, lnk2.dout_line);
      wait_for(2);
      pulse_b(16);
      check("frame b", {exp_frame(sample_b), 3'b000}, bits_b);
      check("result b", sample_b, res_b);
      check("done b", 1, n_done_b[15:0]);
      lnk2.cs_n = 1'b1;
      repeat (10) @(negedge clk_i);
      check("released b", 1, lnk2.dout_oe_n);
      tally_and_finish();
   end
endmodule
